// ### updown_hold_params.svh
// Register map, field layout, reset values and timing of the up/down hold block
`ifndef UPDOWN_HOLD_PARAMS_SVH
`define UPDOWN_HOLD_PARAMS_SVH
// Register byte offsets
`define REG_MODE      8'h00
`define REG_ASSIGN    8'h04
`define REG_BIAS_STEP 8'h08
`define REG_MAX_FREQ  8'h0c
`define REG_LIMITS    8'h10
`define REG_OFFSET1   8'h14
`define REG_OFFSET2   8'h18
`define REG_OFFSET3   8'h1c
`define REG_RATE_ACT  8'h20
`define REG_RATE_FOUR 8'h24
`define REG_SAVED     8'h28
`define REG_STATUS    8'h2c
`define REG_FREQ      8'h30
`define REG_BIAS      8'h34
// Field positions
`define FLD_HOLD      1:0
`define FLD_RSEL      4
`define FLD_RETAIN    8
`define FLD_SRC1      19:16
`define FLD_SRC2      23:20
`define FLD_A_UD      0
`define FLD_A_UD2     1
`define FLD_A_RH      2
`define FLD_STEP      13:0
`define FLD_LO16      15:0
`define FLD_HI16      31:16
`define FLD_UPPER     10:0
`define FLD_LOWER     26:16
`define FLD_OFFS      11:0
// Reset values and constants
`define RST_MAX_FREQ  16'h1770
`define RST_UPPER     11'h3e8
`define RST_RATE      16'h0001
`define SRC_UPDOWN    4'h2
`define PERMILLE      27'h3e8
// Timing: 1 ms adjust tick, 2 s long press
`define CLK_PERIOD_NS 20
`define TICK_TIME_NS  1000000
`define LONG_PRESS_MS 2000
`endif

// ### updown_hold_pkg.sv
// Types shared by the up/down hold block
package updown_hold_pkg;
  typedef logic [15:0] freq_t;
  typedef enum logic [1:0] {
    HOLD_CLEAR  = 2'b00,
    HOLD_SAVE   = 2'b01,
    HOLD_ACCEPT = 2'b10
  } hold_mode_e;
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_SHORT = 2'b01,
    KEY_LONG  = 2'b10
  } key_state_e;
endpackage

// ### updown_hold.sv
// Up/down frequency command hold, bias, offsets and limits with APB registers
//
// Contract
// R1 - Hold mode applies only when up/down or up/down-2 input is assigned.
// R2 - Mode 0: adjust only while running; clear command on stop or power loss.
// R3 - Mode 1: adjust only while running; save on stop, resume on run.
// R4 - Up or down before any run zeroes the saved command.
// R5 - Mode 2: adjust even while stopped; save on stop, resume on restart.
// R6 - Bias step setting 0 to 99.99 Hz, default zero.
// R7 - Zero step: bias ramps while up-2/down-2 held, at selected ramp times.
// R8 - Nonzero step: press under two seconds changes bias by one step.
// R9 - Nonzero step: press over two seconds ramps bias like up/down.
// R10 - Command moves to new value at the bias ramp-select times.
// R11 - Ramp select 0 uses active times, 1 uses fourth time pair.
// R12 - Saved store defaults zero, bounded by maximum and upper limit.
// R13 - Alarm when both up/down and up/down-2 are assigned.
// R14 - Store active: source is terminal up/down, input assigned, mode 1 or 2.
// R15 - Ramp-hold retention applies only when ramp-hold input is assigned.
// R16 - Retention 0: clear command on stop, restart on active command.
// R17 - Retention 1: keep command; clear if ramp-hold open at power-up.
// R18 - Three signed percent offsets added when selected by inputs.
// R19 - Offset command clamped to limits, never reverse.
// R20 - Command above upper limit is limited to it.
// R21 - Saved store survives power loss via nonvolatile reload.
//
// Our own choices: the APB register port and the register offsets.
`include "updown_hold_params.svh"
`timescale 1ns/10ps
`default_nettype none
module updown_hold #(
  parameter int TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS,
  parameter int LONG_TICKS  = `LONG_PRESS_MS
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Terminal inputs and run command
  input  wire logic                  run_cmd,
  input  wire logic                  up_in,
  input  wire logic                  down_in,
  input  wire logic                  up2_in,
  input  wire logic                  down2_in,
  input  wire logic                  hold_in,
  input  wire logic [2:0]            offset_sel,
  input  wire updown_hold_pkg::freq_t ref_freq,
  // Nonvolatile store reload
  input  wire logic                  nv_valid,
  input  wire updown_hold_pkg::freq_t nv_value,
  // Results
  output updown_hold_pkg::freq_t     freq_cmd,
  output updown_hold_pkg::freq_t     saved_value,
  output logic                       assign_alarm
);
  import updown_hold_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic freq_t pct(input logic [10:0] pm, input freq_t mx);
    logic [26:0] p;
    p = 27'(pm) * 27'(mx);
    pct = 16'(p / `PERMILLE);
  endfunction

  function automatic logic signed [18:0] spct(input logic [11:0] pm, input freq_t mx);
    logic signed [29:0] p;
    p = 30'($signed(pm)) * $signed({14'h0000, mx});
    spct = 19'(p / $signed({3'h0, `PERMILLE}));
  endfunction

  function automatic logic signed [18:0] step_to(input logic signed [18:0] cur,
                                                  input logic signed [18:0] tgt,
                                                  input freq_t up, input freq_t dn);
    if (cur < tgt) begin
      step_to = (tgt - cur > $signed({3'h0, up})) ? cur + $signed({3'h0, up}) : tgt;
    end else begin
      step_to = (cur - tgt > $signed({3'h0, dn})) ? cur - $signed({3'h0, dn}) : tgt;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  hold_mode_e  hold_mode_r;
  logic        ramp_sel_r;
  logic        retain_r;
  logic [3:0]  src_one_r;
  logic [3:0]  src_two_r;
  logic [2:0]  assign_r;
  logic [13:0] bias_step_r;
  freq_t       max_freq_r;
  logic [10:0] upper_r;
  logic [10:0] lower_r;
  logic [11:0] off_r [3];
  freq_t       acc_act_r;
  freq_t       dec_act_r;
  freq_t       acc_four_r;
  freq_t       dec_four_r;
  freq_t       saved_r;
  freq_t       saved_nxt;

  // Run-time state
  logic                 init_r;
  logic                 run_r;
  logic                 fresh_r;
  logic [31:0]          tick_cnt_r;
  logic                 tick_r;
  logic signed [18:0]   freq_r;
  logic signed [18:0]   freq_nxt;
  logic signed [18:0]   bias_r;
  logic signed [18:0]   bias_nxt;
  logic signed [18:0]   out_r;
  logic signed [18:0]   out_nxt;
  key_state_e           key_r;
  key_state_e           key_nxt;
  logic [10:0]          press_r;
  logic                 key2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  wire conflict    = assign_r[`FLD_A_UD] & assign_r[`FLD_A_UD2];   // R13
  wire ud_use      = assign_r[`FLD_A_UD] & ~conflict;             // R1
  wire ud2_use     = assign_r[`FLD_A_UD2] & ~conflict;            // R1
  wire mode_en     = ud_use | ud2_use;                            // R1
  wire src_updown  = (src_one_r == `SRC_UPDOWN) | (src_two_r == `SRC_UPDOWN);
  wire store_act   = src_updown & mode_en & (hold_mode_r != HOLD_CLEAR);  // R14
  wire clear_mode  = ~mode_en | (hold_mode_r == HOLD_CLEAR);
  wire adjust_ok   = run_cmd | (mode_en & hold_mode_r == HOLD_ACCEPT);    // R2 R3 R5
  wire stop_evt    = run_r & ~run_cmd;
  wire start_evt   = ~run_r & run_cmd;
  wire rh_use      = assign_r[`FLD_A_RH];                          // R15
  wire keep_cmd    = rh_use & retain_r;                            // R17
  wire key2        = up2_in ^ down2_in;
  wire key2_rise   = key2 & ~key2_r;

  // Limits
  wire freq_t hi_lim  = pct(upper_r, max_freq_r);                  // R20
  wire freq_t lo_lim  = pct(lower_r, max_freq_r);
  wire freq_t hi_cmd  = (hi_lim < max_freq_r) ? hi_lim : max_freq_r;  // R12
  wire logic signed [18:0] hi_s = $signed({3'h0, hi_cmd});
  wire logic signed [18:0] lo_s = $signed({3'h0, lo_lim});

  // Rates: bias ramp select picks active or fourth pair
  wire freq_t acc_sel = ramp_sel_r ? acc_four_r : acc_act_r;       // R11
  wire freq_t dec_sel = ramp_sel_r ? dec_four_r : dec_act_r;       // R11

  // Target: base plus bias plus selected offsets, clamped
  wire logic signed [18:0] base_s = ud_use ? freq_r : $signed({3'h0, ref_freq});
  wire logic signed [18:0] offs =
      (offset_sel[0] ? spct(off_r[0], max_freq_r) : 19'sh0) +
      (offset_sel[1] ? spct(off_r[1], max_freq_r) : 19'sh0) +
      (offset_sel[2] ? spct(off_r[2], max_freq_r) : 19'sh0);        // R18
  wire logic signed [18:0] sum_s = base_s + bias_r + offs;
  wire logic signed [18:0] tgt_s = (sum_s > hi_s) ? hi_s :
                                   (sum_s < lo_s) ? lo_s : sum_s;  // R19 R20
  wire logic signed [18:0] cmd_s = base_s + bias_r;
  wire freq_t save_val = (cmd_s > hi_s) ? hi_cmd :
                         (cmd_s < 19'sh0) ? 16'h0000 : cmd_s[15:0];
  wire logic signed [18:0] adj_s = freq_nxt + bias_r;
  wire freq_t adj_val  = (adj_s > hi_s) ? hi_cmd :
                         (adj_s < 19'sh0) ? 16'h0000 : adj_s[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  wire acc_phase = psel & penable & pready;
  wire wr_en     = acc_phase & pwrite;
  wire mapped    = (paddr <= `REG_BIAS) & (paddr[1:0] == 2'b00);
  wire [31:0] rd_word =
      (paddr == `REG_MODE)      ? {8'h00, src_two_r, src_one_r, 7'h00, retain_r,
                                   3'h0, ramp_sel_r, 2'h0, hold_mode_r} :
      (paddr == `REG_ASSIGN)    ? {29'h0, assign_r} :
      (paddr == `REG_BIAS_STEP) ? {18'h0, bias_step_r} :
      (paddr == `REG_MAX_FREQ)  ? {16'h0, max_freq_r} :
      (paddr == `REG_LIMITS)    ? {5'h0, lower_r, 5'h0, upper_r} :
      (paddr == `REG_OFFSET1)   ? {{20{off_r[0][11]}}, off_r[0]} :
      (paddr == `REG_OFFSET2)   ? {{20{off_r[1][11]}}, off_r[1]} :
      (paddr == `REG_OFFSET3)   ? {{20{off_r[2][11]}}, off_r[2]} :
      (paddr == `REG_RATE_ACT)  ? {dec_act_r, acc_act_r} :
      (paddr == `REG_RATE_FOUR) ? {dec_four_r, acc_four_r} :
      (paddr == `REG_SAVED)     ? {16'h0, saved_r} :
      (paddr == `REG_STATUS)    ? {28'h0, run_r, store_act, mode_en, conflict} :
      (paddr == `REG_FREQ)      ? {16'h0, freq_cmd} :
      (paddr == `REG_BIAS)      ? {{13{bias_r[18]}}, bias_r} : 32'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_word : 32'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_mode_r <= HOLD_CLEAR;                                   // R1
      ramp_sel_r  <= 1'b0;                                         // R11
      retain_r    <= 1'b0;                                         // R15
      src_one_r   <= 4'h0;
      src_two_r   <= 4'h0;
      assign_r    <= 3'h0;
      bias_step_r <= 14'h0;                                        // R6
      max_freq_r  <= `RST_MAX_FREQ;
      upper_r     <= `RST_UPPER;
      lower_r     <= 11'h0;
      off_r       <= '{12'h0, 12'h0, 12'h0};                       // R18
      acc_act_r   <= `RST_RATE;
      dec_act_r   <= `RST_RATE;
      acc_four_r  <= `RST_RATE;
      dec_four_r  <= `RST_RATE;
    end else if (wr_en) begin
      case (paddr)
        `REG_MODE: begin
          hold_mode_r <= (pwdata[`FLD_HOLD] == 2'b11) ? HOLD_CLEAR
                                                     : hold_mode_e'(pwdata[`FLD_HOLD]);
          ramp_sel_r  <= pwdata[`FLD_RSEL];
          retain_r    <= pwdata[`FLD_RETAIN];
          src_one_r   <= pwdata[`FLD_SRC1];
          src_two_r   <= pwdata[`FLD_SRC2];
        end
        `REG_ASSIGN:    assign_r    <= pwdata[2:0];
        `REG_BIAS_STEP: bias_step_r <= pwdata[`FLD_STEP];          // R6
        `REG_MAX_FREQ:  max_freq_r  <= pwdata[`FLD_LO16];
        `REG_LIMITS: begin
          upper_r <= pwdata[`FLD_UPPER];
          lower_r <= pwdata[`FLD_LOWER];
        end
        `REG_OFFSET1:   off_r[0] <= pwdata[`FLD_OFFS];
        `REG_OFFSET2:   off_r[1] <= pwdata[`FLD_OFFS];
        `REG_OFFSET3:   off_r[2] <= pwdata[`FLD_OFFS];
        `REG_RATE_ACT: begin
          acc_act_r <= pwdata[`FLD_LO16];
          dec_act_r <= pwdata[`FLD_HI16];
        end
        `REG_RATE_FOUR: begin
          acc_four_r <= pwdata[`FLD_LO16];
          dec_four_r <= pwdata[`FLD_HI16];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Adjust tick and run tracking
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
      init_r     <= 1'b1;
      run_r      <= 1'b0;
      fresh_r    <= 1'b1;
      key2_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_r + 32'h1;
      init_r     <= 1'b0;
      run_r      <= run_cmd;
      fresh_r    <= stop_evt | (fresh_r & ~run_cmd);
      key2_r     <= key2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Saved-command store
  always_comb begin
    saved_nxt = saved_r;
    if (init_r & nv_valid) begin
      saved_nxt = (nv_value > hi_cmd) ? hi_cmd : nv_value;          // R21
    end else if (wr_en & (paddr == `REG_SAVED)) begin
      saved_nxt = (pwdata[`FLD_LO16] > hi_cmd) ? hi_cmd : pwdata[`FLD_LO16];  // R12
    end else if (stop_evt & store_act) begin
      saved_nxt = save_val;                                        // R3 R5
    end else if (~run_r & ~run_cmd & store_act & (hold_mode_r == HOLD_ACCEPT) & (freq_nxt != freq_r)) begin
      saved_nxt = adj_val;                                         // R5
    end else if (fresh_r & ~run_cmd & store_act & hold_mode_r == HOLD_SAVE &
                 (up_in | down_in | up2_in | down2_in)) begin
      saved_nxt = 16'h0000;                                        // R4
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      saved_r <= 16'h0000;                                         // R12
    end else begin
      saved_r <= saved_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Up/down command
  always_comb begin
    freq_nxt = freq_r;
    if (start_evt & store_act) begin
      freq_nxt = $signed({3'h0, saved_r});                         // R3 R5
    end else if (stop_evt) begin
      freq_nxt = clear_mode ? 19'sh0 : freq_r;                     // R2
    end else if (tick_r & ud_use & adjust_ok & (up_in ^ down_in)) begin
      freq_nxt = step_to(freq_r, up_in ? hi_s : 19'sh0, acc_act_r, dec_act_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Up/down-2 bias with press timing
  always_comb begin
    key_nxt = key_r;
    case (key_r)
      KEY_IDLE:  key_nxt = key2_rise ? KEY_SHORT : KEY_IDLE;
      KEY_SHORT: key_nxt = ~key2 ? KEY_IDLE :
                           (press_r == 11'(LONG_TICKS - 1) & tick_r) ? KEY_LONG : KEY_SHORT;
      KEY_LONG:  key_nxt = key2 ? KEY_LONG : KEY_IDLE;
      default:   key_nxt = KEY_IDLE;
    endcase
  end

  always_comb begin
    bias_nxt = bias_r;
    if (start_evt & store_act) begin
      bias_nxt = 19'sh0;
    end else if (stop_evt & clear_mode) begin
      bias_nxt = 19'sh0;                                           // R2
    end else if (ud2_use & adjust_ok & key2) begin
      if (bias_step_r == 14'h0) begin
        if (tick_r) begin
          bias_nxt = step_to(bias_r, up2_in ? hi_s : -hi_s, acc_sel, dec_sel);  // R7
        end
      end else if (key2_rise) begin
        bias_nxt = step_to(bias_r, up2_in ? hi_s : -hi_s,
                           {2'b00, bias_step_r}, {2'b00, bias_step_r});        // R8
      end else if (key_r == KEY_LONG & tick_r) begin
        bias_nxt = step_to(bias_r, up2_in ? hi_s : -hi_s, acc_act_r, dec_act_r);  // R9
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      freq_r  <= 19'sh0;
      bias_r  <= 19'sh0;
      key_r   <= KEY_IDLE;
      press_r <= 11'h0;
    end else begin
      freq_r  <= freq_nxt;
      bias_r  <= bias_nxt;
      key_r   <= key_nxt;
      press_r <= (key_r != KEY_SHORT) ? 11'h0 : press_r + 11'(tick_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output command ramp, ramp hold and limits
  always_comb begin
    out_nxt = out_r;
    if (init_r) begin
      out_nxt = (keep_cmd & hold_in & nv_valid) ? $signed({3'h0, nv_value}) : 19'sh0;  // R17
    end else if (stop_evt & ~keep_cmd) begin
      out_nxt = 19'sh0;                                            // R16
    end else if (run_cmd & tick_r & ~(rh_use & hold_in)) begin
      out_nxt = step_to(out_r, tgt_s, acc_sel, dec_sel);           // R10
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_r        <= 19'sh0;
      freq_cmd     <= 16'h0000;
      saved_value  <= 16'h0000;
      assign_alarm <= 1'b0;
    end else begin
      out_r        <= out_nxt;
      freq_cmd     <= (out_nxt > hi_s) ? hi_cmd :
                      (out_nxt < 19'sh0) ? 16'h0000 : out_nxt[15:0];  // R19 R20
      saved_value  <= saved_nxt;                                   // R21
      assign_alarm <= conflict;                                    // R13
    end
  end

endmodule // updown_hold
`default_nettype wire

// ### updown_hold_monitor.sv
// Port checker for the up/down frequency command hold block
`timescale 1ns/10ps
`default_nettype none
module updown_hold_monitor
  import updown_hold_pkg::*;
#(
  parameter int TICK_CYCLES = 4,
  parameter int LONG_TICKS  = 5
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Run command and result
  input wire logic        run_cmd,
  input wire freq_t       freq_cmd
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad_setup;
    s_setup ##0 (paddr > 8'h34);
  endsequence
  property p_ready_after_setup; s_setup |=> pready; endproperty
  property p_ready_one; pready |=> !pready; endproperty
  property p_idle_no_ready; !psel |=> !pready; endproperty
  property p_err_unmapped; s_bad_setup |=> pready && pslverr; endproperty
  property p_err_cause; pready && pslverr |-> (paddr > 8'h34 || paddr[1:0] != 2'b00); endproperty
  property p_rd_quiet; !pready |-> prdata == 32'h0; endproperty
  property p_err_rd_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  property p_stop_no_rise; (!run_cmd)[*3] |-> freq_cmd <= $past(freq_cmd); endproperty
  ////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready missing after setup");
  a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
  a_idle_no_ready: assert property (p_idle_no_ready) else $error("pready without request");
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped address");
  a_err_cause: assert property (p_err_cause) else $error("error on mapped address");
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside access");
  a_err_rd_zero: assert property (p_err_rd_zero) else $error("read data on error");
  a_stop_no_rise: assert property (p_stop_no_rise) else $error("command rose while stopped");
endmodule // updown_hold_monitor
bind updown_hold updown_hold_monitor #(.TICK_CYCLES(TICK_CYCLES), .LONG_TICKS(LONG_TICKS)) u_updown_hold_monitor (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd), .freq_cmd(freq_cmd));
`default_nettype wire

// ### terminal_seq_model.sv
// Input terminal and run/stop sequencer model
`timescale 1ns/10ps
`default_nettype none
module terminal_seq_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Requests: run, up, down, up2, down2, hold
  input  wire logic [5:0] req,
  // Terminal levels
  output logic            run_cmd,
  output logic            up_in,
  output logic            down_in,
  output logic            up2_in,
  output logic            down2_in,
  output logic            hold_in
);
  // Terminals sampled like a real input filter, one cycle late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {run_cmd, up_in, down_in, up2_in, down2_in, hold_in} <= 6'h00;
    end else begin
      {run_cmd, up_in, down_in, up2_in, down2_in, hold_in} <= req;
    end
  end
endmodule // terminal_seq_model
`default_nettype wire

// ### updown_hold_tb.sv
// Testbench for the up/down frequency command hold block
`include "updown_hold_params.svh"
`timescale 1ns/10ps
`default_nettype none
module updown_hold_tb;
  import updown_hold_pkg::*;
  localparam int RUN = 5, UP = 4, UP2 = 2, DN2 = 1, HLD = 0;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, nv_valid, assign_alarm, err;
  logic        run_cmd, up_in, down_in, up2_in, down2_in, hold_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0]  req;
  logic [2:0]  offset_sel;
  freq_t       ref_freq, nv_value, freq_cmd, saved_value;
  int          bad_count, num_checks, cyc;
  ////////////////////////////////////////////////////////////////
  updown_hold #(.TICK_CYCLES(4), .LONG_TICKS(5)) u_updown_hold (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
    .up_in(up_in), .down_in(down_in), .up2_in(up2_in), .down2_in(down2_in), .hold_in(hold_in),
    .offset_sel(offset_sel), .ref_freq(ref_freq), .nv_valid(nv_valid), .nv_value(nv_value),
    .freq_cmd(freq_cmd), .saved_value(saved_value), .assign_alarm(assign_alarm));
  terminal_seq_model u_terminal_seq_model (
    .mclk(mclk), .rst_n(rst_n), .req(req), .run_cmd(run_cmd), .up_in(up_in), .down_in(down_in),
    .up2_in(up2_in), .down2_in(down2_in), .hold_in(hold_in));
  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic press(input int b, input int n);
    @(posedge mclk);
    req[b] <= 1'b1;
    tk(n);
    req[b] <= 1'b0;
    tk(4);
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, req, offset_sel, ref_freq} = '0;
    nv_valid = 1'b1;
    nv_value = 16'h0200;
    bad_count = 0;
    num_checks = 0;
    cyc = 0;
    tk(10);
    rst_n <= 1'b1;
    rd(`REG_MAX_FREQ, 32'h00001770);
    rd(`REG_LIMITS, 32'h000003e8);
    rd(`REG_RATE_ACT, 32'h00010001);
    rd(`REG_MODE, 32'h00000000);
    rd(8'h38, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(32'(saved_value), 32'h0200);
    done("reset");
    apb(1'b1, `REG_ASSIGN, 32'h3);
    tk(2);
    chk({31'h0, assign_alarm}, 32'h1);
    apb(1'b1, `REG_ASSIGN, 32'h1);
    tk(2);
    chk({31'h0, assign_alarm}, 32'h0);
    done("alarm");
    apb(1'b1, `REG_MODE, 32'h00020000);
    apb(1'b1, `REG_RATE_ACT, 32'h00400040);
    press(UP, 20);
    req[RUN] <= 1'b1;
    tk(12);
    chk(32'(freq_cmd), 32'h0);
    press(UP, 40);
    chk({31'h0, freq_cmd > 16'h0}, 32'h1);
    req[RUN] <= 1'b0;
    tk(8);
    chk(32'(freq_cmd), 32'h0);
    chk(32'(saved_value), 32'h0200);
    done("mode0");
    apb(1'b1, `REG_MODE, 32'h00020001);
    apb(1'b1, `REG_SAVED, 32'h0100);
    req[RUN] <= 1'b1;
    tk(60);
    chk(32'(freq_cmd), 32'h0100);
    req[RUN] <= 1'b0;
    tk(8);
    chk(32'(saved_value), 32'h0100);
    press(UP, 3);
    chk(32'(saved_value), 32'h0);
    done("mode1");
    apb(1'b1, `REG_MODE, 32'h00020002);
    press(UP, 32);
    req[RUN] <= 1'b1;
    tk(60);
    chk({31'h0, freq_cmd > 16'h0}, 32'h1);
    req[RUN] <= 1'b0;
    tk(8);
    chk({31'h0, saved_value > 16'h0}, 32'h1);
    done("mode2");
    apb(1'b1, `REG_ASSIGN, 32'h2);
    apb(1'b1, `REG_MODE, 32'h00020000);
    apb(1'b1, `REG_BIAS_STEP, 32'h64);
    rd(`REG_BIAS_STEP, 32'h64);
    req[RUN] <= 1'b1;
    press(UP2, 2);
    rd(`REG_BIAS, 32'h64);
    press(DN2, 2);
    rd(`REG_BIAS, 32'h0);
    press(UP2, 160);
    apb(1'b0, `REG_BIAS, 32'h0);
    chk({31'h0, q > 32'h200 && q < 32'h1770}, 32'h1);
    req[RUN] <= 1'b0;
    tk(8);
    rd(`REG_BIAS, 32'h0);
    apb(1'b1, `REG_BIAS_STEP, 32'h0);
    apb(1'b1, `REG_MODE, 32'h00020010);
    apb(1'b1, `REG_RATE_FOUR, 32'h0);
    req[RUN] <= 1'b1;
    press(UP2, 20);
    rd(`REG_BIAS, 32'h0);
    apb(1'b1, `REG_MODE, 32'h00020000);
    press(UP2, 20);
    apb(1'b0, `REG_BIAS, 32'h0);
    chk({31'h0, q > 32'h0}, 32'h1);
    req[RUN] <= 1'b0;
    tk(8);
    done("bias");
    apb(1'b1, `REG_ASSIGN, 32'h4);
    apb(1'b1, `REG_MODE, 32'h00000100);
    ref_freq <= 16'h0400;
    req[RUN] <= 1'b1;
    tk(100);
    chk(32'(freq_cmd), 32'h0400);
    req[HLD] <= 1'b1;
    tk(2);
    ref_freq <= 16'h0800;
    tk(60);
    chk(32'(freq_cmd), 32'h0400);
    req[HLD] <= 1'b0;
    tk(100);
    req[RUN] <= 1'b0;
    tk(8);
    chk(32'(freq_cmd), 32'h0800);
    apb(1'b1, `REG_MODE, 32'h0);
    req[RUN] <= 1'b1;
    tk(8);
    req[RUN] <= 1'b0;
    tk(8);
    chk(32'(freq_cmd), 32'h0);
    done("ramp_hold");
    apb(1'b1, `REG_ASSIGN, 32'h0);
    apb(1'b1, `REG_RATE_ACT, 32'h01000100);
    apb(1'b1, `REG_OFFSET1, 32'h064);
    apb(1'b1, `REG_OFFSET3, 32'hc18);
    rd(`REG_OFFSET3, 32'hfffffc18);
    ref_freq <= 16'h0bb8;
    offset_sel <= 3'b001;
    req[RUN] <= 1'b1;
    tk(80);
    chk(32'(freq_cmd), 32'h0e10);
    offset_sel <= 3'b100;
    tk(80);
    chk(32'(freq_cmd), 32'h0);
    offset_sel <= 3'b000;
    apb(1'b1, `REG_LIMITS, 32'h1f4);
    ref_freq <= 16'h1770;
    tk(80);
    chk(32'(freq_cmd), 32'h0bb8);
    req[RUN] <= 1'b0;
    tk(8);
    done("offsets");
    summarize();
  end
endmodule // updown_hold_tb
`default_nettype wire
